/* File: opm_monitor.sv */
/*
 * fault protection and power-good logic of a point-of-load converter,
 * with an avalon-mm register slave and a level interrupt.
 * assumes measurements arrive already digitised on i_clk.
 */
`include "opm_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module opm_monitor #(
	parameter int DLY_CYC = (`OPM_DLY_NS * (`OPM_CLK_HZ / 1000000)) / 1000,
	parameter int RETRY_CYC = `OPM_RETRY_MS * (`OPM_CLK_HZ / 1000),
	parameter int DCNT_W = 8,
	parameter int RCNT_W = 22
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic [4:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire opm_pkg::opm_meas_t i_meas,
	input wire logic i_ramping_up,
	output logic o_turn_off,
	output logic o_output_window_good,
	output logic o_irq
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [23:0] pct_of(input logic [15:0] v,
		input logic [7:0] p);
		pct_of = v * p;
	endfunction

	function automatic logic [31:0] be_mask(input logic [3:0] be);
		be_mask = '0;
		for (int i = 0; i < 4; i++) begin
			be_mask[i*8 +: 8] = {8{be[i]}};
		end
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	opm_pkg::opm_ctrl_t ctrl_r;
	opm_pkg::opm_fsm_t st_r;
	opm_pkg::opm_fsm_t st_nxt;
	logic [`OPM_NEV-1:0] status_r;
	logic [`OPM_NEV-1:0] status_nxt;
	logic [`OPM_NEV-1:0] mask_r;
	logic [`OPM_NEV-1:0] ev;
	logic [`OPM_NCH-1:0] raw;
	logic [`OPM_NCH-1:0] q_r;
	logic [DCNT_W-1:0] dcnt_r [`OPM_NCH];
	logic [RCNT_W-1:0] rcnt_r;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic wait_r;
	logic off_r;
	logic irq_r;
	logic oc_q_r;
	logic ot_inh_r;
	logic warn_d_r;
	logic pg_d_r;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	// ----------------------------------------
	// thresholds
	// ----------------------------------------
	logic [3:0] oc_sel;
	logic [1:0] ov_sel;
	logic [1:0] uv_sel;
	logic [7:0] oc_pct;
	logic [7:0] ov_pct;
	logic [7:0] uv_pct;
	logic [7:0] pg_lo;
	logic [23:0] v100;
	logic [15:0] trk_diff;
	logic oc_raw;
	logic ov_raw;
	logic uv_raw;
	logic trk_raw;
	logic pg_raw;

	// out-of-range selections clamp to the top step
	assign oc_sel = (ctrl_r.oc_sel > `OPM_OC_MAXSEL) ?
		`OPM_OC_MAXSEL : ctrl_r.oc_sel;
	assign ov_sel = (ctrl_r.ov_sel > `OPM_OV_MAXSEL) ?
		`OPM_OV_MAXSEL : ctrl_r.ov_sel;
	assign uv_sel = (ctrl_r.uv_sel > `OPM_UV_MAXSEL) ?
		`OPM_UV_MAXSEL : ctrl_r.uv_sel;
	assign oc_pct = `OPM_OC_BASE + `OPM_OC_STEP * {4'h0, oc_sel};
	assign ov_pct = `OPM_OV_BASE + `OPM_OV_STEP * {6'h00, ov_sel};
	assign uv_pct = `OPM_UV_BASE + `OPM_UV_STEP * {6'h00, uv_sel};
	assign pg_lo = `OPM_PG_BASE + `OPM_PG_STEP * {7'h00, ctrl_r.pg_sel};
	assign v100 = pct_of(i_meas.vout_mv, `OPM_PCT_FULL);

	assign oc_raw = pct_of(i_meas.iout_ma, `OPM_PCT_FULL) >=
		pct_of(i_meas.irated_ma, oc_pct);
	assign ov_raw = (v100 >= pct_of(i_meas.vset_mv, ov_pct)) &&
		(i_meas.vout_mv >= `OPM_OV_FLOOR_MV);
	// no undervoltage while ramping, the output is still climbing
	assign uv_raw = (v100 < pct_of(i_meas.vset_mv, uv_pct)) &&
		!i_ramping_up;
	assign trk_diff = (i_meas.vout_mv >= i_meas.vref_mv) ?
		i_meas.vout_mv - i_meas.vref_mv : i_meas.vref_mv - i_meas.vout_mv;
	assign trk_raw = ctrl_r.trk_en && i_ramping_up &&
		(trk_diff >= `OPM_TRK_MV);
	assign pg_raw = (v100 >= pct_of(i_meas.vset_mv, pg_lo)) &&
		(v100 <= pct_of(i_meas.vset_mv, `OPM_PG_HI));

	assign raw[`OPM_CH_OV] = ov_raw;
	assign raw[`OPM_CH_UV] = uv_raw;
	assign raw[`OPM_CH_OT] = i_meas.temp_c >= `OPM_OT_OFF_C;
	assign raw[`OPM_CH_TRK] = trk_raw;
	assign raw[`OPM_CH_WARN] = q_r[`OPM_CH_WARN] ?
		(i_meas.temp_c > `OPM_WARN_C - `OPM_WARN_HYST) :
		(i_meas.temp_c >= `OPM_WARN_C);
	assign raw[`OPM_CH_PG] = pg_raw;

	a_ov_floor: assert property ($rose(q_r[`OPM_CH_OV]) |->
		$past(i_meas.vout_mv) >= `OPM_OV_FLOOR_MV)
		else $error("overvoltage trip below absolute floor");
	a_oc_pct_range: assert property (oc_pct >= `OPM_OC_BASE &&
		oc_pct <= 8'haa)
		else $error("overcurrent level out of range");
	a_ov_pct_steps: assert property (ov_pct == 8'h6e ||
		ov_pct == 8'h78 || ov_pct == 8'h82)
		else $error("overvoltage level not a valid step");
	a_uv_pct_steps: assert property (uv_pct == 8'h4b ||
		uv_pct == 8'h50 || uv_pct == 8'h55)
		else $error("undervoltage level not a valid step");
	a_trk_gated: assert property ($rose(q_r[`OPM_CH_TRK]) |->
		$past(ctrl_r.trk_en) && $past(i_ramping_up))
		else $error("tracking checked outside ramp or disabled");

	// ----------------------------------------
	// crossing delay filters
	// ----------------------------------------
	// a change must persist the full delay, glitches restart the count
	for (genvar g = 0; g < `OPM_NCH; g++) begin : g_dly
		logic hit;
		assign hit = (raw[g] != q_r[g]) &&
			(dcnt_r[g] == DCNT_W'(DLY_CYC - 1));
		always_ff @(posedge i_clk or negedge i_nrst) begin
			if (!i_nrst) begin
				dcnt_r[g] <= '0;
				q_r[g] <= 1'b0;
			end else begin
				dcnt_r[g] <= (raw[g] == q_r[g] || hit) ? '0 :
					dcnt_r[g] + 1'b1;
				q_r[g] <= hit ? raw[g] : q_r[g];
			end
		end
	end

	a_ov_delay: assert property ($rose(q_r[`OPM_CH_OV]) |->
		$past(dcnt_r[`OPM_CH_OV]) == DCNT_W'(DLY_CYC - 1))
		else $error("overvoltage qualified before its delay");
	a_warn_delay: assert property ($rose(q_r[`OPM_CH_WARN]) |->
		$past(dcnt_r[`OPM_CH_WARN]) == DCNT_W'(DLY_CYC - 1))
		else $error("warning asserted before its delay");
	a_warn_hyst: assert property ($fell(q_r[`OPM_CH_WARN]) |->
		$past(i_meas.temp_c) <= `OPM_WARN_C - `OPM_WARN_HYST)
		else $error("warning cleared above hysteresis point");
	a_pg_delay: assert property ($changed(q_r[`OPM_CH_PG]) |->
		$past(dcnt_r[`OPM_CH_PG]) == DCNT_W'(DLY_CYC - 1))
		else $error("window-good changed before its delay");
	a_pg_window: assert property ($changed(q_r[`OPM_CH_PG]) |->
		$past(pg_raw) == o_output_window_good)
		else $error("window-good disagrees with window");

	// ----------------------------------------
	// fault sequencer
	// ----------------------------------------
	logic [4:0] flt;
	logic [4:0] latch_vec;
	logic trip;
	logic trip_latch;
	logic retry_done;
	logic clr_latch;

	assign flt = {q_r[`OPM_CH_TRK], q_r[`OPM_CH_OT], q_r[`OPM_CH_UV],
		q_r[`OPM_CH_OV], oc_q_r};
	assign latch_vec = {ctrl_r.trk_latch, ctrl_r.latch};
	assign trip = (st_r == opm_pkg::OPM_RUN) && (|flt);
	assign trip_latch = |(flt & latch_vec);
	assign retry_done = rcnt_r == RCNT_W'(RETRY_CYC - 1);

	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			opm_pkg::OPM_RUN: begin
				if (trip) begin
					st_nxt = trip_latch ? opm_pkg::OPM_LATCH :
						opm_pkg::OPM_RETRY;
				end
			end
			opm_pkg::OPM_RETRY: begin
				if (retry_done && !ot_inh_r) begin
					st_nxt = opm_pkg::OPM_RUN;
				end
			end
			opm_pkg::OPM_LATCH: begin
				if (clr_latch && !ot_inh_r) begin
					st_nxt = opm_pkg::OPM_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_r <= opm_pkg::OPM_RUN;
			off_r <= 1'b0;
			oc_q_r <= 1'b0;
			rcnt_r <= '0;
		end else begin
			st_r <= st_nxt;
			off_r <= st_nxt != opm_pkg::OPM_RUN;
			oc_q_r <= oc_raw;
			rcnt_r <= (st_r != opm_pkg::OPM_RETRY) ? '0 :
				(retry_done ? rcnt_r : rcnt_r + 1'b1);
		end
	end

	// set wins over the cool-down clear
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ot_inh_r <= 1'b0;
		end else if (trip && flt[`OPM_ST_OT]) begin
			ot_inh_r <= 1'b1;
		end else if (i_meas.temp_c <= `OPM_OT_ON_C) begin
			ot_inh_r <= 1'b0;
		end
	end

	sequence s_retry_trip;
		trip && !trip_latch;
	endsequence
	sequence s_latch_trip;
		trip && trip_latch;
	endsequence
	a_retry_entry: assert property (s_retry_trip |=>
		st_r == opm_pkg::OPM_RETRY && o_turn_off)
		else $error("non-latching trip did not start retry");
	a_retry_hold: assert property (st_r == opm_pkg::OPM_RETRY &&
		!retry_done |=> o_turn_off)
		else $error("output restarted before retry period");
	a_latch_entry: assert property (s_latch_trip |=>
		st_r == opm_pkg::OPM_LATCH && o_turn_off)
		else $error("latching trip did not latch");
	a_latch_hold: assert property (st_r == opm_pkg::OPM_LATCH &&
		!clr_latch |=> st_r == opm_pkg::OPM_LATCH)
		else $error("latched fault released without clear");
	a_ot_restart: assert property (st_r != opm_pkg::OPM_RUN &&
		ot_inh_r |=> st_r != opm_pkg::OPM_RUN)
		else $error("restart while still hot");

	// ----------------------------------------
	// events and interrupt
	// ----------------------------------------
	assign ev[4:0] = trip ? flt : 5'h00;
	assign ev[`OPM_ST_WARN] = q_r[`OPM_CH_WARN] & ~warn_d_r;
	assign ev[`OPM_ST_PG] = q_r[`OPM_CH_PG] ^ pg_d_r;

	// ----------------------------------------
	// avalon-mm slave, one wait cycle per access
	// ----------------------------------------
	logic req;
	logic acc;
	logic [31:0] wmask;
	logic [31:0] ctrl_wr;
	logic [31:0] mask_wr;
	logic wr_ctrl;
	logic wr_mask;
	logic rd_status;
	logic [31:0] state_word;

	assign req = i_avs_read | i_avs_write;
	assign acc = req && !wait_r;
	assign wmask = be_mask(i_avs_byteenable);
	assign ctrl_wr = ({17'h00000, ctrl_r} & ~wmask) |
		(i_avs_writedata & wmask);
	assign mask_wr = ({25'h0000000, mask_r} & ~wmask) |
		(i_avs_writedata & wmask);
	assign wr_ctrl = acc && i_avs_write &&
		i_avs_address == `OPM_ADDR_CTRL;
	assign wr_mask = acc && i_avs_write &&
		i_avs_address == `OPM_ADDR_MASK;
	assign clr_latch = acc && i_avs_write && i_avs_byteenable[0] &&
		i_avs_writedata[0] && i_avs_address == `OPM_ADDR_CLEAR;
	assign rd_status = acc && i_avs_read &&
		i_avs_address == `OPM_ADDR_STATUS;
	assign status_nxt = (rd_status ? status_r & ~rdata_r[`OPM_NEV-1:0] :
		status_r) | ev;
	assign state_word = {26'h0000000, ot_inh_r,
		st_r == opm_pkg::OPM_LATCH, st_r == opm_pkg::OPM_RETRY,
		q_r[`OPM_CH_WARN], q_r[`OPM_CH_PG], off_r};
	assign rdata_nxt =
		(i_avs_address == `OPM_ADDR_CTRL) ? {17'h00000, ctrl_r} :
		(i_avs_address == `OPM_ADDR_STATUS) ? {25'h0000000, status_r} :
		(i_avs_address == `OPM_ADDR_MASK) ? {25'h0000000, mask_r} :
		(i_avs_address == `OPM_ADDR_STATE) ? state_word : 32'h00000000;

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			wait_r <= 1'b1;
			rdata_r <= 32'h00000000;
		end else begin
			wait_r <= !(req && wait_r);
			rdata_r <= (req && wait_r) ? rdata_nxt : rdata_r;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ctrl_r <= `OPM_CTRL_RST;
			mask_r <= `OPM_EV_RST;
			status_r <= `OPM_EV_RST;
			irq_r <= 1'b0;
			warn_d_r <= 1'b0;
			pg_d_r <= 1'b0;
		end else begin
			ctrl_r <= wr_ctrl ? ctrl_wr[14:0] : ctrl_r;
			mask_r <= wr_mask ? mask_wr[6:0] : mask_r;
			status_r <= status_nxt;
			irq_r <= |(status_nxt & mask_r);
			warn_d_r <= q_r[`OPM_CH_WARN];
			pg_d_r <= q_r[`OPM_CH_PG];
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign o_avs_readdata = rdata_r;
	assign o_avs_waitrequest = wait_r;
	assign o_turn_off = off_r;
	assign o_output_window_good = q_r[`OPM_CH_PG];
	assign o_irq = irq_r;

endmodule // opm_monitor

`default_nettype wire

/* File: opm_regs.svh */
/*
 * register offsets, reset values, thresholds and timing of the
 * output fault protection monitor.
 * assumes byte addressing on a 32-bit avalon-mm slave.
 */
`ifndef OPM_REGS_SVH
`define OPM_REGS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define OPM_ADDR_CTRL 5'h00
`define OPM_ADDR_STATUS 5'h04
`define OPM_ADDR_MASK 5'h08
`define OPM_ADDR_STATE 5'h0c
`define OPM_ADDR_CLEAR 5'h10
`define OPM_CTRL_RST 15'h002a
`define OPM_EV_RST 7'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define OPM_CLK_HZ 20000000
`define OPM_DLY_NS 6000
`define OPM_RETRY_MS 130

// ----------------------------------------
// thresholds, percent of setpoint or rating, else in mV or degrees C
// ----------------------------------------
`define OPM_PCT_FULL 8'h64
`define OPM_OC_BASE 8'h3c
`define OPM_OC_STEP 8'h0b
`define OPM_OC_MAXSEL 4'ha
`define OPM_OV_BASE 8'h6e
`define OPM_OV_STEP 8'h0a
`define OPM_OV_MAXSEL 2'h2
`define OPM_OV_FLOOR_MV 16'h03e8
`define OPM_UV_BASE 8'h4b
`define OPM_UV_STEP 8'h05
`define OPM_UV_MAXSEL 2'h2
`define OPM_PG_BASE 8'h5a
`define OPM_PG_STEP 8'h05
`define OPM_PG_HI 8'h6e
`define OPM_OT_OFF_C 8'h82
`define OPM_OT_ON_C 8'h78
`define OPM_WARN_C 8'h78
`define OPM_WARN_HYST 8'h03
`define OPM_TRK_MV 16'h00fa

// ----------------------------------------
// filter channels and status bits
// ----------------------------------------
`define OPM_NCH 6
`define OPM_CH_OV 0
`define OPM_CH_UV 1
`define OPM_CH_OT 2
`define OPM_CH_TRK 3
`define OPM_CH_WARN 4
`define OPM_CH_PG 5
`define OPM_NEV 7
`define OPM_ST_OC 0
`define OPM_ST_OV 1
`define OPM_ST_UV 2
`define OPM_ST_OT 3
`define OPM_ST_TRK 4
`define OPM_ST_WARN 5
`define OPM_ST_PG 6

`endif

/* File: opm_pkg.sv */
/*
 * types of the output fault protection monitor.
 * assumes nothing of its surroundings.
 */
`default_nettype none

package opm_pkg;

	// ----------------------------------------
	// control word, measurements and sequencer states
	// ----------------------------------------
	typedef struct packed {
		logic trk_latch;
		logic trk_en;
		logic [3:0] latch;
		logic pg_sel;
		logic [1:0] uv_sel;
		logic [1:0] ov_sel;
		logic [3:0] oc_sel;
	} opm_ctrl_t;

	typedef struct packed {
		logic [15:0] vout_mv;
		logic [15:0] vset_mv;
		logic [15:0] vref_mv;
		logic [15:0] iout_ma;
		logic [15:0] irated_ma;
		logic [7:0] temp_c;
	} opm_meas_t;

	typedef enum logic [1:0] {
		OPM_RUN,
		OPM_RETRY,
		OPM_LATCH
	} opm_fsm_t;

endpackage

`default_nettype wire

/* File: opm_host.sv */
/*
 * power manager side model: avalon-mm master reaching the monitor.
 * assumes one clock shared with the slave, which answers by
 * dropping waitrequest for one cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module opm_host (
	input wire logic i_clk,
	input wire logic [31:0] i_readdata,
	input wire logic i_waitrequest,
	output logic [4:0] o_address,
	output logic o_read,
	output logic o_write,
	output logic [31:0] o_writedata
);
	// ----------------------------------------
	// bus access
	// ----------------------------------------
	initial begin
		o_address = 5'h1f;
		o_read = 1'b0;
		o_write = 1'b0;
		o_writedata = 32'h0;
	end

	// call just after a rising edge; ok low means the wait ran out
	task automatic xfer(input logic w, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic ok);
		int n;
		ok = 1'b0;
		q = 32'h0;
		o_address <= a;
		o_writedata <= d;
		o_write <= w;
		o_read <= !w;
		for (n = 0; n < 20 && !ok; n++) begin
			@(posedge i_clk);
			if (i_waitrequest === 1'b0) begin
				ok = 1'b1;
				q = i_readdata;
			end
		end
		o_write <= 1'b0;
		o_read <= 1'b0;
		// released data must not look valid
		o_writedata <= ~d;
		// one idle edge so strobes never toggle twice in a step
		@(posedge i_clk);
	endtask
endmodule // opm_host

`default_nettype wire

/* File: opm_monitor_tb_top.sv */
/*
 * self-checking bench of the output fault protection monitor.
 * assumes opm_host speaks the register bus; short delay and retry
 * counts keep the run brief.
 */
`include "opm_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module opm_monitor_tb_top;
	localparam int DLY = 8;
	localparam int RTY = 300;
	logic i_clk;
	logic i_nrst;
	logic ramp;
	logic [4:0] adr;
	logic rd;
	logic wr;
	logic [31:0] wd;
	logic [31:0] rdat;
	logic wt;
	logic off;
	logic pg;
	logic irq;
	logic ok;
	logic [31:0] q;
	opm_pkg::opm_meas_t m;
	int errors;
	int checks;

	opm_monitor #(.DLY_CYC(DLY), .RETRY_CYC(RTY), .DCNT_W(8),
		.RCNT_W(22)) uut (.i_clk(i_clk), .i_nrst(i_nrst),
		.i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wd), .i_avs_byteenable(4'hf),
		.o_avs_readdata(rdat), .o_avs_waitrequest(wt), .i_meas(m),
		.i_ramping_up(ramp), .o_turn_off(off),
		.o_output_window_good(pg), .o_irq(irq));

	opm_host host (.i_clk(i_clk), .i_readdata(rdat),
		.i_waitrequest(wt), .o_address(adr), .o_read(rd),
		.o_write(wr), .o_writedata(wd));

	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic print_verdict();
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic rd_chk(input logic [4:0] a, input logic [31:0] k,
		input logic [31:0] e);
		host.xfer(1'b0, a, 32'h0, q, ok);
		chk({31'h0, ok}, 32'h1);
		if (ok !== 1'b1)
			print_verdict();
		chk(q & k, e);
	endtask

	task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, q, ok);
		chk({31'h0, ok}, 32'h1);
		if (ok !== 1'b1)
			print_verdict();
	endtask

	function automatic logic sig(input int s);
		return s == 0 ? off : (s == 1 ? pg : irq);
	endfunction

	// bounded wait for a flag: 0 turn-off, 1 window, 2 irq
	task automatic wait_for(input int s, input logic v, input int n);
		int k;
		for (k = 0; k < n && sig(s) !== v; k++)
			@(posedge i_clk);
		chk({31'h0, sig(s)}, {31'h0, v});
		if (sig(s) !== v)
			print_verdict();
	endtask

	task automatic hold(input int s, input logic v, input int n);
		repeat (n) begin
			@(posedge i_clk);
			chk({31'h0, sig(s)}, {31'h0, v});
		end
	endtask

	task automatic setm(input logic [15:0] vs, input logic [15:0] vo,
		input logic [15:0] io, input logic [7:0] t);
		m.vset_mv <= vs;
		m.vout_mv <= vo;
		m.iout_ma <= io;
		m.temp_c <= t;
		@(posedge i_clk);
	endtask

	task automatic back();
		setm(16'h09c4, 16'h09c4, 16'h03e8, 8'h19);
		wait_for(0, 1'b0, RTY + DLY + 20);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		errors = 0;
		checks = 0;
		i_nrst = 1'b0;
		ramp = 1'b0;
		m = {16'h09c4, 16'h09c4, 16'h09c4, 16'h03e8, 16'h2710, 8'h19};
		repeat (4) @(posedge i_clk);
		i_nrst <= 1'b1;
		@(posedge i_clk);
		rd_chk(`OPM_ADDR_CTRL, 32'hffffffff, 32'h2a);
		rd_chk(5'h14, 32'hffffffff, 32'h0);
		wait_for(1, 1'b1, DLY + 4);
		wr_reg(`OPM_ADDR_MASK, 32'h0);
		rd_chk(`OPM_ADDR_STATUS, 32'h40, 32'h40);
		// 88 percent: out of window; masked event keeps irq low
		setm(16'h09c4, 16'h0898, 16'h03e8, 8'h19);
		hold(1, 1'b1, DLY - 2);
		wait_for(1, 1'b0, 6);
		hold(2, 1'b0, 3);
		wr_reg(`OPM_ADDR_MASK, 32'h7f);
		wait_for(2, 1'b1, 4);
		rd_chk(`OPM_ADDR_STATUS, 32'h40, 32'h40);
		wait_for(2, 1'b0, 4);
		setm(16'h09c4, 16'h08ca, 16'h03e8, 8'h19);
		wait_for(1, 1'b1, DLY + 4);
		wr_reg(`OPM_ADDR_CTRL, 32'h12a);
		wait_for(1, 1'b0, DLY + 4);
		wr_reg(`OPM_ADDR_CTRL, 32'h2a);
		// overvoltage just under and at 130 percent
		setm(16'h09c4, 16'h0cb1, 16'h03e8, 8'h19);
		hold(0, 1'b0, DLY + 4);
		setm(16'h09c4, 16'h0cb2, 16'h03e8, 8'h19);
		hold(0, 1'b0, DLY - 2);
		wait_for(0, 1'b1, 6);
		rd_chk(`OPM_ADDR_STATUS, 32'h2, 32'h2);
		setm(16'h09c4, 16'h09c4, 16'h03e8, 8'h19);
		hold(0, 1'b1, RTY - 20);
		wait_for(0, 1'b0, 40);
		// absolute floor on a low setpoint
		wr_reg(`OPM_ADDR_CTRL, 32'h00a);
		setm(16'h02bc, 16'h0384, 16'h03e8, 8'h19);
		hold(0, 1'b0, DLY + 4);
		setm(16'h02bc, 16'h03e8, 16'h03e8, 8'h19);
		wait_for(0, 1'b1, DLY + 4);
		back();
		// undervoltage at 85 percent
		wr_reg(`OPM_ADDR_CTRL, 32'h0aa);
		setm(16'h09c4, 16'h084d, 16'h03e8, 8'h19);
		hold(0, 1'b0, DLY + 4);
		setm(16'h09c4, 16'h084c, 16'h03e8, 8'h19);
		wait_for(0, 1'b1, DLY + 4);
		back();
		// overcurrent at both ends of the range
		wr_reg(`OPM_ADDR_CTRL, 32'h2a);
		setm(16'h09c4, 16'h09c4, 16'h4267, 8'h19);
		hold(0, 1'b0, 4);
		setm(16'h09c4, 16'h09c4, 16'h4268, 8'h19);
		wait_for(0, 1'b1, 4);
		back();
		wr_reg(`OPM_ADDR_CTRL, 32'h220);
		setm(16'h09c4, 16'h09c4, 16'h176f, 8'h19);
		hold(0, 1'b0, 4);
		setm(16'h09c4, 16'h09c4, 16'h1770, 8'h19);
		wait_for(0, 1'b1, 4);
		setm(16'h09c4, 16'h09c4, 16'h03e8, 8'h19);
		hold(0, 1'b1, RTY + 20);
		rd_chk(`OPM_ADDR_STATE, 32'h10, 32'h10);
		wr_reg(`OPM_ADDR_CLEAR, 32'h1);
		wait_for(0, 1'b0, 4);
		wr_reg(`OPM_ADDR_CTRL, 32'h2a);
		// warning with hysteresis, no shutdown
		setm(16'h09c4, 16'h09c4, 16'h03e8, 8'h78);
		hold(0, 1'b0, DLY + 4);
		rd_chk(`OPM_ADDR_STATE, 32'h4, 32'h4);
		setm(16'h09c4, 16'h09c4, 16'h03e8, 8'h76);
		hold(0, 1'b0, DLY + 4);
		rd_chk(`OPM_ADDR_STATE, 32'h4, 32'h4);
		setm(16'h09c4, 16'h09c4, 16'h03e8, 8'h75);
		hold(0, 1'b0, DLY + 4);
		rd_chk(`OPM_ADDR_STATE, 32'h4, 32'h0);
		// overtemperature: restart held off until 120 C
		setm(16'h09c4, 16'h09c4, 16'h03e8, 8'h82);
		hold(0, 1'b0, DLY - 2);
		wait_for(0, 1'b1, 6);
		setm(16'h09c4, 16'h09c4, 16'h03e8, 8'h7d);
		hold(0, 1'b1, RTY + 20);
		setm(16'h09c4, 16'h09c4, 16'h03e8, 8'h78);
		wait_for(0, 1'b0, DLY + 20);
		// tracking: off by default, then 249 mV below holds and 250 mV above trips
		ramp <= 1'b1;
		setm(16'h09c4, 16'h08ca, 16'h03e8, 8'h19);
		hold(0, 1'b0, DLY + 4);
		wr_reg(`OPM_ADDR_CTRL, 32'h202a);
		setm(16'h09c4, 16'h08cb, 16'h03e8, 8'h19);
		hold(0, 1'b0, DLY + 4);
		setm(16'h09c4, 16'h0abe, 16'h03e8, 8'h19);
		wait_for(0, 1'b1, DLY + 4);
		ramp <= 1'b0;
		back();
		print_verdict();
	end
endmodule // opm_monitor_tb_top

`default_nettype wire
